// ===== fifo_ctrl.sv
// Purpose: pointers, fill count and output stage of the transmit fifo
// Assumes: storage answers a read one clock later
// Notes: output stage is a register; one entry drains every three clocks at best
`timescale 1ns/100ps
module fifo_ctrl
	import xfer_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16,
	parameter int AW = $clog2(DEPTH)
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready,
	// entries held in storage
	output logic [AW:0] level,
	// storage port
	fifo_mem_if.ctrl port
);
	logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [AW:0] cnt_q, cnt_d;
	logic out_valid_q, out_valid_d, rd_pend_q, rd_pend_d;
	logic [WIDTH-1:0] out_data_q, out_data_d;
	logic push, fetch;

	// full is honest: no push beyond DEPTH stored entries
	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign push = in_valid & in_ready;
	// fetch only into an empty output stage, which costs throughput but saves a skid buffer
	assign fetch = (cnt_q != '0) & ~out_valid_q & ~rd_pend_q;
	assign port.wr_en = push;
	assign port.wr_addr = wr_ptr_q;
	assign port.wr_data = in_data;
	assign port.rd_en = fetch;
	assign port.rd_addr = rd_ptr_q;
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;
	assign level = cnt_q;

	// next pointers, count and output stage
	always_comb
	begin
		wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
		rd_ptr_d = fetch ? rd_ptr_q + 1'b1 : rd_ptr_q;
		case ({push, fetch})
			2'b10: cnt_d = cnt_q + 1'b1;
			2'b01: cnt_d = cnt_q - 1'b1;
			default: cnt_d = cnt_q;
		endcase
		rd_pend_d = fetch;
		out_valid_d = out_valid_q & ~out_ready;
		out_data_d = out_data_q;
		if (rd_pend_q)
		begin
			out_valid_d = 1'b1;
			out_data_d = port.rd_data;
		end
	end

	// registers
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q <= '0;
			rd_pend_q <= 1'b0;
			out_valid_q <= 1'b0;
			out_data_q <= '0;
		end
		else
		begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			cnt_q <= cnt_d;
			rd_pend_q <= rd_pend_d;
			out_valid_q <= out_valid_d;
			out_data_q <= out_data_d;
		end
	end
endmodule

// ===== fifo_mem.sv
// Purpose: storage array of the transmit fifo
// Assumes: one write and one read per clock at most
// Notes: read data come out of a register
`timescale 1ns/100ps
module fifo_mem
	import xfer_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
)
(
	// clock
	input wire logic core_clk,
	// storage port
	fifo_mem_if.mem port
);
	logic [WIDTH-1:0] store [DEPTH];
	logic [WIDTH-1:0] rd_data_q;

	// array write and registered read; no reset, contents are don't-care until written
	always_ff @(posedge core_clk)
	begin
		if (port.wr_en)
		begin
			store[port.wr_addr] <= port.wr_data;
		end
		if (port.rd_en)
		begin
			rd_data_q <= store[port.rd_addr];
		end
	end

	assign port.rd_data = rd_data_q;
endmodule

// ===== fifo_mem_if.sv
// Purpose: carries the storage port between fifo control and fifo memory
// Assumes: read data arrive one clock after the read enable
// Notes: one write port, one read port
`timescale 1ns/100ps
interface fifo_mem_if #(parameter int WIDTH = 32, parameter int AW = 4);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [WIDTH-1:0] wr_data;
	logic rd_en;
	logic [AW-1:0] rd_addr;
	logic [WIDTH-1:0] rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en,
		output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_en,
		input rd_addr, output rd_data);
endinterface

// ===== tb_transfer_ctrl_tx.sv
// Purpose: self-checking bench of the transmit transfer channel
// Assumes: far model returns the inverse of the address
// Notes: expected words queue up; a watcher pops them as results appear
`timescale 1ns/100ps
module tb_transfer_ctrl_tx;
	logic core_clk, srst, reg_wr, reg_rd, serial_end_event, chain_start, stall, rd_q;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, mem_addr, mem_rdata, ch_addr, ch_data, lf;
	logic mem_rd, ch_wr, ch_ready, xfer_end, chain_next;
	logic [31:0] e_v, rq[$], chq[$];
	int n_errors, checked, k, n_end, n_chain;
	transfer_ctrl_tx #(.FIFO_DEPTH(16)) i_transfer_ctrl_tx (.core_clk(core_clk),
		.srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_end_event(serial_end_event),
		.chain_start(chain_start), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .ch_wr(ch_wr), .ch_addr(ch_addr), .ch_data(ch_data),
		.ch_ready(ch_ready), .xfer_end(xfer_end), .chain_next(chain_next));
	xfer_far_model i_xfer_far_model (.core_clk(core_clk), .srst(srst), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata), .stall(stall), .ch_ready(ch_ready));
	function automatic logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic summarize();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		rq.push_back({16'h0000, e});
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask
	// one activation pulse, then room for the three-cycle unit
	task automatic ev(input logic c);
		@(posedge core_clk);
		if (c)
			chain_start <= 1'b1;
		else
			serial_end_event <= 1'b1;
		@(posedge core_clk);
		chain_start <= 1'b0;
		serial_end_event <= 1'b0;
		repeat (8) @(posedge core_clk);
	endtask
	task automatic ex(input logic [15:0] a, input logic [7:0] d);
		chq.push_back({a, 8'h00, d});
	endtask
	task automatic drain();
		k = 0;
		while (chq.size() != 0 && k < 500)
		begin
			@(posedge core_clk);
			k++;
		end
		if (chq.size() != 0)
		begin
			n_errors++;
			$display("BAD drain expected 0 seen %0d", chq.size());
			chq.delete();
		end
		repeat (20) @(posedge core_clk);
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// watcher: random channel stalls, read data and channel words against the notes
	always @(posedge core_clk)
	begin
		rd_q <= reg_rd;
		lf <= nxt(lf);
		stall <= lf[0];
		// descriptor event pulses are counted and judged after the first, third and last scenarios
		if (xfer_end === 1'b1)
			n_end++;
		if (chain_next === 1'b1)
			n_chain++;
		if (rd_q)
		begin
			e_v = rq.pop_front();
			chk("reg_rdata", e_v, {16'h0000, reg_rdata});
		end
		if (ch_wr === 1'b1 && ch_ready === 1'b1)
		begin
			if (chq.size() == 0)
				chk("unexpected ch_wr", 32'h0000_0000, {ch_addr, ch_data});
			else
				chk("ch_addr_data", chq.pop_front(), {ch_addr, ch_data});
		end
	end
	initial
	begin
		{reg_wr, reg_rd, serial_end_event, chain_start, stall, rd_q} = '0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		lf = 16'hEF93; // starts at 61331
		srst = 1'b1;
		repeat (4) @(posedge core_clk);
		srst <= 1'b0;
		for (int i = 0; i < 8; i++)
			rd(i[3:0], 16'h0000);
		rd(4'h8, 16'h2000);
		rd(4'hF, 16'h0000);
		wr(4'h7, 16'h00FD);
		rd(4'h7, 16'h00FD);
		wr(4'h0, 16'h0004);
		wr(4'h1, 16'h0001);
		wr(4'h2, 16'h0007);
		wr(4'h3, 16'hE911);
		wr(4'h4, 16'hFF10);
		wr(4'h6, 16'h0008);
		rd(4'h6, 16'h0008);
		wr(4'hF, 16'hFFFF);
		rd(4'hF, 16'h0000);
		for (int i = 0; i < 7; i++)
		begin
			ex(16'hFF10, ~(8'h11 + i[7:0]));
			ev(1'b0);
		end
		ev(1'b0);
		drain();
		rd(4'h2, 16'h0000);
		chk("xfer_end", 32'h0000_0001, n_end);
		wr(4'h6, 16'h0000);
		rd(4'h6, 16'h0000);
		wr(4'h2, 16'h0002);
		ev(1'b0);
		drain();
		rd(4'h2, 16'h0002);
		wr(4'h0, 16'h0018);
		wr(4'h3, 16'hE911);
		for (int i = 0; i < 2; i++)
		begin
			ex(16'hFF10 + i[15:0], 8'hEE);
			ev(1'b1);
		end
		drain();
		chk("chain_next", 32'h0000_0002, n_chain);
		chk("xfer_end", 32'h0000_0002, n_end);
		wr(4'h0, 16'h0007);
		wr(4'h5, 16'h0002);
		wr(4'h2, 16'h0002);
		wr(4'h3, 16'hE911);
		wr(4'h4, 16'hFF10);
		wr(4'h6, 16'h0008);
		ex(16'hFF10, 8'hEE);
		ex(16'hFF10, 8'hED);
		ex(16'hFF10, 8'hEE);
		repeat (3) ev(1'b0);
		drain();
		chk("xfer_end", 32'h0000_0002, n_end);
		summarize();
	end
endmodule

// ===== transfer_ctrl_tx.sv
// Purpose: transmit descriptor engine moving buffer bytes into the serial data register
// Assumes: memory answers a read strobe with data on the next clock
// Notes: descriptor kept in registers; moved units queue in a fifo toward the channel
//
// Contract
// - source address fixed or incremented per control
// - destination address fixed or incremented per control
// - mode bit picks normal or repeat
// - enable bit set starts transfer per event
// - enable bit clear ignores serial end events
// - enable bit reads back its state
// - base address register holds descriptor area
`include "xfer_map.svh"
`timescale 1ns/100ps
module transfer_ctrl_tx
	import xfer_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// activation sources
	input wire logic serial_end_event,
	input wire logic chain_start,
	// memory read port
	output logic mem_rd,
	output logic [15:0] mem_addr,
	input wire logic [15:0] mem_rdata,
	// serial channel data register write
	output logic ch_wr,
	output logic [15:0] ch_addr,
	output logic [15:0] ch_data,
	input wire logic ch_ready,
	// descriptor events
	output logic xfer_end,
	output logic chain_next
);
	localparam int FW = 32;
	localparam int FAW = $clog2(FIFO_DEPTH);

	state_type state_q, state_d;
	logic [7:0] ctrl_q, ctrl_d, bsize_q, bsize_d, cnt_q, cnt_d, reload_q, reload_d;
	logic [7:0] act_q, act_d, base_q, base_d;
	logic [15:0] src_q, src_d, dst_q, dst_d, src_start_q, src_start_d;
	logic [15:0] dst_start_q, dst_start_d, data_q, data_d, rdata_q, rdata_d;
	logic [15:0] mem_addr_q, mem_addr_d, step, src_next, dst_next;
	logic [8:0] blk_q, blk_d;
	logic [7:0] cnt_next;
	logic pend_q, pend_d, mem_rd_q, mem_rd_d, end_q, end_d, chn_q, chn_d;
	logic trig, take, cnt_nz, push_valid, fifo_ready, wr_hit;
	logic [FW-1:0] fifo_out;
	logic [FAW:0] fifo_level;

	fifo_mem_if #(.WIDTH(FW), .AW(FAW)) mem_port ();

	// transmit queue toward the serial channel
	fifo_ctrl #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.srst(srst),
		.in_valid(push_valid),
		.in_data({dst_q, data_q}),
		.in_ready(fifo_ready),
		.out_valid(ch_wr),
		.out_data(fifo_out),
		.out_ready(ch_ready),
		.level(fifo_level),
		.port(mem_port.ctrl)
	);

	fifo_mem #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_mem (
		.core_clk(core_clk),
		.port(mem_port.mem)
	);

	assign ch_addr = fifo_out[31:16];
	assign ch_data = fifo_out[15:0];
	assign mem_rd = mem_rd_q;
	assign mem_addr = mem_addr_q;
	assign reg_rdata = rdata_q;
	assign xfer_end = end_q;
	assign chain_next = chn_q;

	// serial end events only count while the enable bit is set; chain starts do not need it
	assign trig = serial_end_event & act_q[`ACT_SERIAL_END_BIT];
	// a spent normal-mode count makes the channel deaf
	assign cnt_nz = (cnt_q != `RST_BYTE);
	assign take = (state_q == ST_IDLE) & cnt_nz & (pend_q | trig | chain_start);
	assign push_valid = (state_q == ST_PUSH);
	// word size steps by two, byte size by one
	assign step = ctrl_q[`CTRL_DATA_SIZE_BIT] ? `STEP_WORD : `STEP_BYTE;
	assign src_next = ctrl_q[`CTRL_SOURCE_INC_BIT] ? src_q + step : src_q;
	assign dst_next = ctrl_q[`CTRL_DEST_INC_BIT] ? dst_q + step : dst_q;
	assign cnt_next = cnt_q - `ONE_BYTE;
	assign wr_hit = reg_wr;

	// pending activation: one held while busy; a new event beats a same-cycle consume
	always_comb
	begin
		pend_d = (pend_q & ~take) | ((trig | chain_start) & cnt_nz & ~(take & ~pend_q));
	end

	// sequencer: fetch a unit, then push it with its destination into the queue
	always_comb
	begin
		state_d = state_q;
		blk_d = blk_q;
		src_d = src_q;
		dst_d = dst_q;
		cnt_d = cnt_q;
		data_d = data_q;
		mem_rd_d = 1'b0;
		mem_addr_d = mem_addr_q;
		end_d = 1'b0;
		chn_d = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				if (take)
				begin
					blk_d = {(bsize_q == `RST_BYTE), bsize_q};
					mem_rd_d = 1'b1;
					mem_addr_d = src_q;
					state_d = ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				// the strobe cycle carries no data yet; memory answers one clock later
				if (!mem_rd_q)
				begin
					// byte size keeps only the low lane
					data_d = {8'h00, mem_rdata[7:0]};
					if (ctrl_q[`CTRL_DATA_SIZE_BIT])
					begin
						data_d = mem_rdata;
					end
					state_d = ST_PUSH;
				end
			end
			ST_PUSH:
			begin
				if (fifo_ready)
				begin
					src_d = src_next;
					dst_d = dst_next;
					blk_d = blk_q - 1'b1;
					if (blk_q == 9'h001)
					begin
						state_d = ST_IDLE;
						cnt_d = cnt_next;
						chn_d = ctrl_q[`CTRL_CHAIN_BIT];
						if (cnt_next == `RST_BYTE)
						begin
							if (ctrl_q[`CTRL_MODE_BIT])
							begin
								// repeat mode wraps the count and the repeat area
								cnt_d = reload_q;
								end_d = ctrl_q[`CTRL_REPEAT_INT_BIT];
								if (ctrl_q[`CTRL_REPEAT_AREA_BIT])
								begin
									src_d = src_start_q;
								end
								else
								begin
									dst_d = dst_start_q;
								end
							end
							else
							begin
								end_d = 1'b1;
							end
						end
					end
					else
					begin
						mem_rd_d = 1'b1;
						mem_addr_d = src_next;
						state_d = ST_WAIT;
					end
				end
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
		// a software write overrides the engine's own update in the same cycle
		ctrl_d = ctrl_q;
		bsize_d = bsize_q;
		reload_d = reload_q;
		act_d = act_q;
		base_d = base_q;
		src_start_d = src_start_q;
		dst_start_d = dst_start_q;
		if (wr_hit)
		begin
			case (reg_addr)
				`REG_CONTROL: ctrl_d = reg_wdata[7:0];
				`REG_BLOCK_SIZE: bsize_d = reg_wdata[7:0];
				`REG_TRANSFER_COUNT: cnt_d = reg_wdata[7:0];
				`REG_SOURCE_ADDRESS:
				begin
					src_d = reg_wdata;
					src_start_d = reg_wdata;
				end
				`REG_DEST_ADDRESS:
				begin
					dst_d = reg_wdata;
					dst_start_d = reg_wdata;
				end
				`REG_COUNT_RELOAD: reload_d = reg_wdata[7:0];
				`REG_ACTIVATION_ENABLE_1: act_d = reg_wdata[7:0];
				`REG_BASE_ADDRESS: base_d = reg_wdata[7:0];
				default: ctrl_d = ctrl_q;
			endcase
		end
	end

	// read mux; data stand only in the cycle after the strobe, unmapped reads give zero
	always_comb
	begin
		rdata_d = `RST_WORD;
		if (reg_rd)
		begin
			case (reg_addr)
				`REG_CONTROL: rdata_d = {8'h00, ctrl_q};
				`REG_BLOCK_SIZE: rdata_d = {8'h00, bsize_q};
				`REG_TRANSFER_COUNT: rdata_d = {8'h00, cnt_q};
				`REG_SOURCE_ADDRESS: rdata_d = src_q;
				`REG_DEST_ADDRESS: rdata_d = dst_q;
				`REG_COUNT_RELOAD: rdata_d = {8'h00, reload_q};
				`REG_ACTIVATION_ENABLE_1: rdata_d = {8'h00, act_q};
				`REG_BASE_ADDRESS: rdata_d = {8'h00, base_q};
				`REG_STATUS:
				begin
					rdata_d[`STAT_BUSY_BIT] = (state_q != ST_IDLE);
					rdata_d[`STAT_PENDING_BIT] = pend_q;
					rdata_d[`STAT_COUNT_ZERO_BIT] = ~cnt_nz;
					rdata_d[FAW:0] = fifo_level;
				end
				default: rdata_d = `RST_WORD;
			endcase
		end
	end

	// registers
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			state_q <= ST_IDLE;
			ctrl_q <= `RST_BYTE;
			bsize_q <= `RST_BYTE;
			cnt_q <= `RST_BYTE;
			reload_q <= `RST_BYTE;
			act_q <= `RST_BYTE;
			base_q <= `RST_BYTE;
			src_q <= `RST_WORD;
			dst_q <= `RST_WORD;
			src_start_q <= `RST_WORD;
			dst_start_q <= `RST_WORD;
			data_q <= `RST_WORD;
			rdata_q <= `RST_WORD;
			mem_addr_q <= `RST_WORD;
			blk_q <= '0;
			pend_q <= 1'b0;
			mem_rd_q <= 1'b0;
			end_q <= 1'b0;
			chn_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
			bsize_q <= bsize_d;
			cnt_q <= cnt_d;
			reload_q <= reload_d;
			act_q <= act_d;
			base_q <= base_d;
			src_q <= src_d;
			dst_q <= dst_d;
			src_start_q <= src_start_d;
			dst_start_q <= dst_start_d;
			data_q <= data_d;
			rdata_q <= rdata_d;
			mem_addr_q <= mem_addr_d;
			blk_q <= blk_d;
			pend_q <= pend_d;
			mem_rd_q <= mem_rd_d;
			end_q <= end_d;
			chn_q <= chn_d;
		end
	end
endmodule

// ===== xfer_asserts.sv
// Purpose: port-level checks of the transmit transfer channel
// Assumes: either data size, chaining on or off; descriptor rewritten only while idle
// Notes: software writes are mirrored to judge address modes
`timescale 1ns/100ps
module xfer_asserts
	import xfer_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// memory and channel
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	input wire logic ch_wr,
	input wire logic [15:0] ch_addr,
	input wire logic [15:0] ch_data,
	input wire logic ch_ready,
	input wire logic chain_next
);
	logic [7:0] ctl_q, ctl_d, en_q, en_d;
	logic [15:0] src_q, src_d, dst_q, dst_d;
	// mirror of written values; only start values, the engine's stepping is not copied
	always_comb
	begin
		ctl_d = (reg_wr && reg_addr == 4'h0) ? reg_wdata[7:0] : ctl_q;
		src_d = (reg_wr && reg_addr == 4'h3) ? reg_wdata : src_q;
		dst_d = (reg_wr && reg_addr == 4'h4) ? reg_wdata : dst_q;
		en_d = (reg_wr && reg_addr == 4'h6) ? reg_wdata[7:0] : en_q;
	end
	always_ff @(posedge core_clk)
	begin
		ctl_q <= srst ? 8'h00 : ctl_d;
		src_q <= srst ? 16'h0000 : src_d;
		dst_q <= srst ? 16'h0000 : dst_d;
		en_q <= srst ? 8'h00 : en_d;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence gap_s;
		!mem_rd [*2];
	endsequence
	sequence held_s;
		ch_wr && $stable(ch_addr) && $stable(ch_data);
	endsequence
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read");
	rd_enable_a: assert property (reg_rd && reg_addr == 4'h6 |=> reg_rdata == {8'h00, en_q})
		else $error("enable register read back wrong");
	ch_hold_a: assert property (ch_wr && !ch_ready |=> held_s)
		else $error("channel word changed while waiting");
	mem_space_a: assert property (mem_rd |=> gap_s)
		else $error("memory reads closer than three cycles");
	dst_fixed_a: assert property (ch_wr && !ctl_q[3] |-> ch_addr == dst_q)
		else $error("fixed destination moved");
	src_fixed_a: assert property (mem_rd && !ctl_q[2] && !ctl_q[0] |-> mem_addr == src_q)
		else $error("fixed source moved");
	byte_hi_a: assert property (ch_wr && !ctl_q[6] |-> ch_data[15:8] == 8'h00)
		else $error("byte transfer with upper data");
	chain_off_a: assert property (!ctl_q[4] |-> !chain_next)
		else $error("chain pulse with chaining off");
endmodule
bind transfer_ctrl_tx xfer_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) i_xfer_asserts (
	.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_rd(mem_rd),
	.mem_addr(mem_addr), .ch_wr(ch_wr), .ch_addr(ch_addr), .ch_data(ch_data),
	.ch_ready(ch_ready), .chain_next(chain_next));

// ===== xfer_far_model.sv
// Purpose: memory buffer and serial channel beside the transfer channel
// Assumes: memory data valid only in the cycle after a read strobe
// Notes: stored byte is the inverse of its address
`timescale 1ns/100ps
module xfer_far_model
(
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// memory read port
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	output logic [15:0] mem_rdata,
	// channel side
	input wire logic stall,
	output logic ch_ready
);
	logic [15:0] d_q;
	logic v_q;
	// outside the answer cycle the bus shows the inverse, so late sampling is caught
	always_ff @(posedge core_clk)
	begin
		v_q <= srst ? 1'b0 : mem_rd;
		if (mem_rd)
		begin
			d_q <= ~mem_addr; // buffer filled beforehand by the receive side
		end
	end
	assign mem_rdata = v_q ? d_q : ~d_q;
	assign ch_ready = !stall; // bench stalls the channel at random
endmodule

// ===== xfer_map.svh
// Purpose: offsets, field positions and reset values of the transmit transfer channel
// Assumes: register index is the word address on the plain register port
// Notes: definitions only
`ifndef XFER_MAP_SVH
`define XFER_MAP_SVH

// register indices
`define REG_CONTROL 4'h0
`define REG_BLOCK_SIZE 4'h1
`define REG_TRANSFER_COUNT 4'h2
`define REG_SOURCE_ADDRESS 4'h3
`define REG_DEST_ADDRESS 4'h4
`define REG_COUNT_RELOAD 4'h5
`define REG_ACTIVATION_ENABLE_1 4'h6
`define REG_BASE_ADDRESS 4'h7
`define REG_STATUS 4'h8

// control byte fields
`define CTRL_DATA_SIZE_BIT 6
`define CTRL_REPEAT_INT_BIT 5
`define CTRL_CHAIN_BIT 4
`define CTRL_DEST_INC_BIT 3
`define CTRL_SOURCE_INC_BIT 2
`define CTRL_REPEAT_AREA_BIT 1
`define CTRL_MODE_BIT 0

// activation enable register 1 field
`define ACT_SERIAL_END_BIT 3

// status register fields
`define STAT_BUSY_BIT 15
`define STAT_PENDING_BIT 14
`define STAT_COUNT_ZERO_BIT 13

// reset values and fixed figures
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define ONE_BYTE 8'h01
`define STEP_BYTE 16'h0001
`define STEP_WORD 16'h0002

`endif

// ===== xfer_pkg.sv
// Purpose: shared types of the transmit transfer channel
// Assumes: nothing beyond the map header
// Notes: one-hot state codes written out
package xfer_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_PUSH = 3'b100
	} state_type;
endpackage
